//--- rtl/eisv_defines.vh
// Constants for the external interrupt sense and vector map block
`ifndef EISV_DEFINES_VH
`define EISV_DEFINES_VH

// Register indices; byte address is four times the index
`define EISV_IDX_PRIO0 6'h24
`define EISV_IDX_PRIO1 6'h25
`define EISV_IDX_PRIO2 6'h26
`define EISV_IDX_PRIO3 6'h27
`define EISV_IDX_SENSE 6'h28
`define EISV_IDX_STAT 6'h29
`define EISV_IDX_MASK 6'h2a
`define EISV_IDX_PEND 6'h2b

// Reset values and read only priority bits
`define EISV_PRIO_RST 8'hff
`define EISV_SENSE_RST 8'h00
`define EISV_PRIO3_RO 8'hf0

// Sense control field positions
`define EISV_G2_HI 7
`define EISV_G2_LO 6
`define EISV_IPB_BIT 5
`define EISV_G1_HI 4
`define EISV_G1_LO 3
`define EISV_G0_HI 2
`define EISV_G0_LO 1
`define EISV_IPA_BIT 0

// Sense codes and priority level 0 code
`define EISV_FALL_LOW 2'h0
`define EISV_RISE 2'h1
`define EISV_FALL 2'h2
`define EISV_BOTH 2'h3
`define EISV_PRIO_LVL0 2'h2

// Vector table
`define EISV_NUM_VEC 14
`define EISV_VEC_TOP 16'hfffa
`define EISV_WAKE_HALT 14'h111c
`define EISV_WAKE_AHALT 14'h111e
`endif

//--- rtl/eisv_pin_sense.v
// Edge and level detector for one external interrupt pin
`timescale 1ns/10ps
`include "eisv_defines.vh"
module eisv_pin_sense (
    input wire clock,
    input wire resetn,
    input wire pin,
    input wire enable,
    input wire [1:0] sense,
    input wire invert,
    output wire edge_hit,
    output wire level_hit
);
    reg prev_r;
    wire eff;
    wire prev_eff;
    wire fall;
    wire rise;

    // Raw pin is kept so a polarity change with the pin steady never
    // looks like an edge: both samples get the same inversion
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= pin;
        end
    end

    assign eff = pin ^ invert;
    assign prev_eff = prev_r ^ invert;
    assign fall = prev_eff & ~eff;
    assign rise = ~prev_eff & eff;

    assign edge_hit = enable & (
        (sense == `EISV_FALL_LOW) ? fall :
        (sense == `EISV_RISE) ? rise :
        (sense == `EISV_FALL) ? fall : (rise | fall));
    assign level_hit = enable & (sense == `EISV_FALL_LOW) & ~eff;
endmodule

//--- rtl/eisv_req_latch.v
// Request latch for one external interrupt vector
`timescale 1ns/10ps
module eisv_req_latch (
    input wire clock,
    input wire resetn,
    input wire edge_set,
    input wire level_req,
    input wire masked,
    input wire ack,
    input wire flush,
    output wire req
);
    reg pend_r;

    // A new edge in the cycle of a clear is kept
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_r <= 1'b0;
        end else if (edge_set) begin
            pend_r <= 1'b1;
        end else if (ack | flush) begin
            pend_r <= 1'b0;
        end
    end

    // Level requests are not latched: they return after service
    assign req = (pend_r | level_req) & ~masked;
endmodule

//--- rtl/eisv_ctrl.v
// External interrupt sense, priority storage and vector map
// How it works
// - Fourteen vectors, emergency stop at fffa highest, pwm timer at ffe0 lowest.
// - External, serial peripheral and voltage vectors can wake.
// - Time base and safe oscillator wake from active halt only.
// - Writing a changed sense or polarity value clears pending external requests.
// - A vector is masked while one of its enabled interrupt pins is forced low.
// - Sense and polarity bits are written only at current priority level 3.
// - Sense codes: 00 fall and low, 01 rise, 10 fall, 11 both.
// - Rise and high level exists only for groups 0 and 2 by inversion.
// - Bits 7:6 set group 2 sense; polarity b swaps its subgroup.
// - Bit 5 inverts group 2 subgroup when set; level 3 writes only.
// - Bits 4:3 set group 1 sense with no inversion.
// - Bits 2:1 set group 0 sense; bit 0 inverts one subgroup.
// - Sense control register resets to zero.
// - Four priority registers hold two bits per vector, reset to ones.
// - Enabled pins of one group are detected then ORed.
// - Edge requests are latched and cleared on entering service.
// - A priority field write of 10 is ignored for that field.
`timescale 1ns/10ps
`include "eisv_defines.vh"
module eisv_ctrl (
    input wire clock,
    input wire resetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire cur_prio_hi,
    input wire cur_prio_lo,
    input wire [15:0] ext_pins,
    input wire [15:0] pin_irq_en,
    input wire [15:0] pin_forced_low,
    input wire [2:0] ext_ack,
    input wire [10:0] periph_req,
    output reg [13:0] irq_pending_r,
    output reg top_valid_r,
    output reg [3:0] top_vec_r,
    output reg [15:0] top_addr_r,
    output reg wake_halt_r,
    output reg wake_active_halt_r,
    output reg [31:0] vec_prio_r,
    output reg irq_r
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] prio0_r;
    reg [7:0] prio1_r;
    reg [7:0] prio2_r;
    reg [7:0] prio3_r;
    reg [7:0] sense_r;
    reg [3:0] stat_r;
    reg [3:0] mask_r;
    reg [31:0] rd_nxt;
    reg hit_nxt;
    reg [3:0] top_nxt;
    reg found_nxt;
    reg [3:0] stat_nxt;
    integer k;

    wire [5:0] idx;
    wire acc;
    wire setup_acc;
    wire wr;
    wire level3;
    wire sense_wr;
    wire sense_refused;
    wire flush;
    wire [15:0] edge_hit;
    wire [15:0] level_hit;
    wire [2:0] grp_edge;
    wire [2:0] grp_level;
    wire [2:0] grp_mask;
    wire [2:0] ext_req;
    wire [13:0] pend_nxt;
    wire [3:0] ev;
    wire sel_prio0;
    wire sel_prio1;
    wire sel_prio2;
    wire sel_prio3;
    wire sel_sense;
    wire sel_stat;
    wire sel_mask;
    wire [7:0] prio0_nxt;
    wire [7:0] prio1_nxt;
    wire [7:0] prio2_nxt;
    wire [7:0] prio3_nxt;
    wire [15:0] addr_nxt;
    wire wake_halt_nxt;
    wire wake_ahalt_nxt;
    wire irq_nxt;

    wire [1:0] g0_sense = sense_r[`EISV_G0_HI:`EISV_G0_LO];
    wire [1:0] g1_sense = sense_r[`EISV_G1_HI:`EISV_G1_LO];
    wire [1:0] g2_sense = sense_r[`EISV_G2_HI:`EISV_G2_LO];
    wire polarity_invert_a = sense_r[`EISV_IPA_BIT];
    wire polarity_invert_b = sense_r[`EISV_IPB_BIT];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One wait state keeps pready and prdata on flip-flops
    assign idx = paddr[7:2];
    assign setup_acc = psel & penable & ~pready;
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign level3 = cur_prio_hi & cur_prio_lo;
    assign sense_wr = wr & sel_sense & level3;
    assign sense_refused = wr & sel_sense & ~level3;
    assign flush = sense_wr & (pwdata[7:0] != sense_r);

    // Keeps each two-bit field whose new value would be level 0
    function [7:0] prio_merge;
        input [7:0] old;
        input [7:0] nw;
        integer f;
        begin
            prio_merge = nw;
            for (f = 0; f < 4; f = f + 1) begin
                if (nw[2*f +: 2] == `EISV_PRIO_LVL0) begin
                    prio_merge[2*f +: 2] = old[2*f +: 2];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Register select
    // ----------------------------------------------------------------
    // Address bits 1:0 are ignored: every register is one aligned word
    assign sel_prio0 = (idx == `EISV_IDX_PRIO0);
    assign sel_prio1 = (idx == `EISV_IDX_PRIO1);
    assign sel_prio2 = (idx == `EISV_IDX_PRIO2);
    assign sel_prio3 = (idx == `EISV_IDX_PRIO3);
    assign sel_sense = (idx == `EISV_IDX_SENSE);
    assign sel_stat = (idx == `EISV_IDX_STAT);
    assign sel_mask = (idx == `EISV_IDX_MASK);

    // Merged values are ready every cycle, used only by a write
    assign prio0_nxt = prio_merge(prio0_r, pwdata[7:0]);
    assign prio1_nxt = prio_merge(prio1_r, pwdata[7:0]);
    assign prio2_nxt = prio_merge(prio2_r, pwdata[7:0]);
    // Upper half of the last register has no vectors
    assign prio3_nxt = prio_merge(prio3_r, pwdata[7:0]) | `EISV_PRIO3_RO;

    always @* begin
        rd_nxt = 32'h0;
        hit_nxt = 1'b1;
        case (idx)
            `EISV_IDX_PRIO0: rd_nxt[7:0] = prio0_r;
            `EISV_IDX_PRIO1: rd_nxt[7:0] = prio1_r;
            `EISV_IDX_PRIO2: rd_nxt[7:0] = prio2_r;
            `EISV_IDX_PRIO3: rd_nxt[7:0] = prio3_r;
            `EISV_IDX_SENSE: rd_nxt[7:0] = sense_r;
            `EISV_IDX_STAT: rd_nxt[3:0] = stat_r;
            `EISV_IDX_MASK: rd_nxt[3:0] = mask_r;
            `EISV_IDX_PEND: rd_nxt[13:0] = irq_pending_r;
            default: hit_nxt = 1'b0;
        endcase
    end

    // Read data are captured in the first access cycle, before any write
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_acc;
            if (setup_acc) begin
                prdata <= pwrite ? 32'h0 : rd_nxt;
                pslverr <= ~hit_nxt;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Priority, sense control and mask registers
    // ----------------------------------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prio0_r <= `EISV_PRIO_RST;
            prio1_r <= `EISV_PRIO_RST;
            prio2_r <= `EISV_PRIO_RST;
            prio3_r <= `EISV_PRIO_RST;
            sense_r <= `EISV_SENSE_RST;
            mask_r <= 4'h0;
        end else begin
            if (wr && sel_prio0) begin
                prio0_r <= prio0_nxt;
            end
            if (wr && sel_prio1) begin
                prio1_r <= prio1_nxt;
            end
            if (wr && sel_prio2) begin
                prio2_r <= prio2_nxt;
            end
            if (wr && sel_prio3) begin
                prio3_r <= prio3_nxt;
            end
            if (sense_wr) begin
                sense_r <= pwdata[7:0];
            end
            if (wr && sel_mask) begin
                mask_r <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin detection
    // ----------------------------------------------------------------
    // Pins 2:0 group 0 plain, 5:3 group 0 polarity a,
    // 9:6 group 1, 12:10 group 2 polarity b, 15:13 group 2 plain
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_pin
            wire [1:0] sel_sense;
            wire sel_inv;
            assign sel_sense = (i < 6) ? g0_sense :
                (i < 10) ? g1_sense : g2_sense;
            assign sel_inv = (i >= 3 && i < 6) ? polarity_invert_a :
                (i >= 10 && i < 13) ? polarity_invert_b : 1'b0;
            eisv_pin_sense u_sense (
                .clock(clock),
                .resetn(resetn),
                .pin(ext_pins[i]),
                .enable(pin_irq_en[i]),
                .sense(sel_sense),
                .invert(sel_inv),
                .edge_hit(edge_hit[i]),
                .level_hit(level_hit[i])
            );
        end
    endgenerate

    assign grp_edge[0] = |edge_hit[5:0];
    assign grp_edge[1] = |edge_hit[9:6];
    assign grp_edge[2] = |edge_hit[15:10];
    assign grp_level[0] = |level_hit[5:0];
    assign grp_level[1] = |level_hit[9:6];
    assign grp_level[2] = |level_hit[15:10];
    assign grp_mask[0] = |(pin_irq_en[5:0] & pin_forced_low[5:0]);
    assign grp_mask[1] = |(pin_irq_en[9:6] & pin_forced_low[9:6]);
    assign grp_mask[2] = |(pin_irq_en[15:10] & pin_forced_low[15:10]);

    // ----------------------------------------------------------------
    // External request latches
    // ----------------------------------------------------------------
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_vec
            eisv_req_latch u_latch (
                .clock(clock),
                .resetn(resetn),
                .edge_set(grp_edge[i]),
                .level_req(grp_level[i]),
                .masked(grp_mask[i]),
                .ack(ext_ack[i]),
                .flush(flush),
                .req(ext_req[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Vector map and wake tags
    // ----------------------------------------------------------------
    assign pend_nxt = {periph_req[10:2], ext_req, periph_req[1:0]};

    // Peripheral vectors arrive as levels; only 2..4 are latched here
    // Lowest index is the highest hardware priority
    always @* begin
        top_nxt = 4'h0;
        found_nxt = 1'b0;
        for (k = `EISV_NUM_VEC - 1; k >= 0; k = k - 1) begin
            if (pend_nxt[k]) begin
                top_nxt = k[3:0];
                found_nxt = 1'b1;
            end
        end
    end

    // Address and wake tags share the pending set of the same cycle
    assign addr_nxt = `EISV_VEC_TOP - {11'h0, top_nxt, 1'b0};
    assign wake_halt_nxt = |(pend_nxt & `EISV_WAKE_HALT);
    assign wake_ahalt_nxt = |(pend_nxt & `EISV_WAKE_AHALT);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_pending_r <= 14'h0;
            top_valid_r <= 1'b0;
            top_vec_r <= 4'h0;
            top_addr_r <= `EISV_VEC_TOP;
            wake_halt_r <= 1'b0;
            wake_active_halt_r <= 1'b0;
            vec_prio_r <= 32'hffffffff;
        end else begin
            irq_pending_r <= pend_nxt;
            top_valid_r <= found_nxt;
            top_vec_r <= top_nxt;
            top_addr_r <= addr_nxt;
            wake_halt_r <= wake_halt_nxt;
            wake_active_halt_r <= wake_ahalt_nxt;
            vec_prio_r <= {prio3_r, prio2_r, prio1_r, prio0_r};
        end
    end

    // ----------------------------------------------------------------
    // Status, mask and interrupt line
    // ----------------------------------------------------------------
    // Events: edge caught per external vector, refused sense write.
    // Set beats the write-one clear of the same cycle.
    assign ev = {sense_refused, grp_edge};

    always @* begin
        stat_nxt = stat_r | ev;
        if (wr && sel_stat) begin
            stat_nxt = (stat_r & ~pwdata[3:0]) | ev;
        end
    end

    // Interrupt line lags status by one cycle
    assign irq_nxt = |(stat_r & mask_r);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stat_r <= 4'h0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
        end
    end
endmodule

//--- verif/eisv_cpu_model.sv
// CPU side model that fetches external vectors
`timescale 1ns/10ps
module eisv_cpu_model (
    input wire clock,
    input wire resetn,
    input wire serve,
    input wire slow,
    input wire top_valid_r,
    input wire [3:0] top_vec_r,
    output logic [2:0] ext_ack
);
    logic [1:0] dly_r;
    // Fetch pulses only for external vectors; slow adds a stall
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_ack <= 3'h0;
            dly_r <= 2'h0;
        end else begin
            ext_ack <= 3'h0;
            if (serve && top_valid_r && top_vec_r inside {[2:4]}
                && ext_ack == 3'h0) begin
                if (dly_r == (slow ? 2'h3 : 2'h0)) begin
                    ext_ack <= 3'h1 << (top_vec_r - 4'h2);
                    dly_r <= 2'h0;
                end else begin
                    dly_r <= dly_r + 2'h1;
                end
            end else begin
                // Stall count restarts whenever no fetch is waiting
                dly_r <= 2'h0;
            end
        end
    end
endmodule

//--- verif/eisv_ctrl_checker.sv
// Port level assertions for the interrupt sense block
`timescale 1ns/10ps
module eisv_chk (
    input wire clock,
    input wire resetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [13:0] irq_pending_r,
    input wire top_valid_r,
    input wire [3:0] top_vec_r,
    input wire [15:0] top_addr_r,
    input wire wake_halt_r,
    input wire wake_active_halt_r,
    input wire [31:0] vec_prio_r,
    input wire [15:0] pin_irq_en,
    input wire [15:0] pin_forced_low
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic lvl0;
    // Level 0 must never be stored in any field
    always @* begin
        lvl0 = 1'b0;
        for (int i = 0; i < 16; i++)
            lvl0 = lvl0 | (vec_prio_r[2*i+:2] == 2'h2);
    end
    a_rdy_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    a_rdy_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_bad_addr: assert property (pready && (paddr[7:2] < 6'h24
        || paddr[7:2] > 6'h2b) |-> pslverr)
        else $error("unmapped access without error");
    a_prio_top: assert property (vec_prio_r[31:28] == 4'hf)
        else $error("read only priority bits changed");
    a_no_lvl0: assert property (!lvl0)
        else $error("priority level 0 stored");
    a_top_addr: assert property (top_valid_r |->
        top_addr_r == 16'hfffa - {11'h0, top_vec_r, 1'b0})
        else $error("vector address wrong");
    a_vec0_top: assert property (irq_pending_r[0] [*2] |->
        top_valid_r && top_vec_r == 4'h0)
        else $error("emergency stop not on top");
    a_wake_none: assert property (!(|(irq_pending_r & 14'h111c)) [*2]
        |-> !wake_halt_r)
        else $error("halt wake without capable source");
    a_wake_act: assert property (!(|(irq_pending_r & 14'h111e)) [*2]
        |-> !wake_active_halt_r)
        else $error("active halt wake without source");
    a_wake_ext: assert property (irq_pending_r[2] [*2] |-> wake_halt_r)
        else $error("external vector does not wake");
    a_mask_pin: assert property ((|(pin_irq_en[5:0] & pin_forced_low[5:0]))
        [*3] |-> !irq_pending_r[2])
        else $error("forced low pin did not mask");
endmodule
bind eisv_ctrl eisv_chk u_chk (.clock, .resetn, .paddr, .psel, .penable,
    .pready, .pslverr, .irq_pending_r, .top_valid_r, .top_vec_r,
    .top_addr_r, .wake_halt_r, .wake_active_halt_r, .vec_prio_r,
    .pin_irq_en, .pin_forced_low);

//--- verif/ext_irq_sense_and_vector_map_test.sv
// Self-checking testbench for the interrupt sense block
`timescale 1ns/10ps
module ext_irq_sense_and_vector_map_test;
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic cur_prio_hi = 1, cur_prio_lo = 1, serve = 0, slow = 0, rerr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [15:0] ext_pins = 16'hffff, pin_irq_en = 0, pin_forced_low = 0;
    logic [10:0] periph_req = 0;
    wire [2:0] ext_ack;
    wire [31:0] prdata, vec_prio_r;
    wire pready, pslverr, top_valid_r, wake_halt_r, wake_active_halt_r;
    wire irq_r;
    wire [13:0] irq_pending_r;
    wire [3:0] top_vec_r;
    wire [15:0] top_addr_r;
    int error_cnt = 0, n_tests = 0;
    eisv_ctrl dut (.clock, .resetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .cur_prio_hi, .cur_prio_lo,
        .ext_pins, .pin_irq_en, .pin_forced_low, .ext_ack, .periph_req,
        .irq_pending_r, .top_valid_r, .top_vec_r, .top_addr_r,
        .wake_halt_r, .wake_active_halt_r, .vec_prio_r, .irq_r);
    eisv_cpu_model cpu (.clock, .resetn, .serve, .slow, .top_valid_r,
        .top_vec_r, .ext_ack);
    initial forever #10 clock = ~clock;
    // ------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Idle cycle after each transfer keeps psel from two writes per step
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(pready, 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 8'h0);
        chk(rdat, e);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        stop_test;
    end
    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1;
        for (int i = 0; i < 4; i++) rd(8'h90 + 8'(4 * i), 32'hff);
        rd(8'ha0, 32'h0);
        apb(0, 8'hfc, 8'h0);
        chk(rerr, 1'b1);
        chk(rdat, 32'h0);
        wr(8'h90, 8'hcf);
        wr(8'h90, 8'h64);
        rd(8'h90, 32'h44);
        chk(vec_prio_r[7:0], 8'h44);
        wr(8'h9c, 8'h00);
        rd(8'h9c, 32'hf0);
        {cur_prio_hi, cur_prio_lo} <= 2'h2;
        wr(8'ha0, 8'h10);
        rd(8'ha0, 32'h0);
        rd(8'ha4, 32'h8);
        wr(8'ha4, 8'h8);
        {cur_prio_hi, cur_prio_lo} <= 2'h3;
        wr(8'ha0, 8'h10);
        rd(8'ha0, 32'h10);
        pin_irq_en[6] <= 1;
        ext_pins[6] <= 0;
        cyc(4);
        chk(irq_pending_r[3], 1'b1);
        chk(top_addr_r, 16'hfff4);
        chk(top_valid_r, 1'b1);
        chk(top_vec_r, 4'h3);
        chk(wake_halt_r, 1'b1);
        rd(8'ha4, 32'h2);
        wr(8'ha8, 8'h2);
        cyc(2);
        chk(irq_r, 1'b1);
        wr(8'ha8, 8'h0);
        cyc(2);
        chk(irq_r, 1'b0);
        wr(8'ha4, 8'h2);
        wr(8'ha8, 8'h2);
        cyc(2);
        chk(irq_r, 1'b0);
        slow <= 1;
        serve <= 1;
        cyc(8);
        serve <= 0;
        chk(irq_pending_r[3], 1'b0);
        ext_pins[6] <= 1;
        cyc(4);
        chk(irq_pending_r[3], 1'b0);
        ext_pins[6] <= 0;
        cyc(4);
        chk(irq_pending_r[3], 1'b1);
        wr(8'ha0, 8'h18);
        cyc(1);
        chk(irq_pending_r[3], 1'b0);
        ext_pins[6] <= 1;
        cyc(4);
        chk(irq_pending_r[3], 1'b1);
        slow <= 0;
        serve <= 1;
        cyc(4);
        serve <= 0;
        pin_irq_en[6] <= 0;
        chk(irq_pending_r[3], 1'b0);
        // Pin 14 of group 2 in rising mode: its fall leaves vector 4 idle, its rise sets it
        pin_irq_en[14:13] <= 2'h3;
        wr(8'ha0, 8'h58);
        ext_pins[14] <= 0;
        cyc(4);
        chk(irq_pending_r[4], 1'b0);
        ext_pins[14] <= 1;
        cyc(4);
        chk(irq_pending_r[4], 1'b1);
        serve <= 1;
        cyc(4);
        serve <= 0;
        pin_irq_en[0] <= 1;
        ext_pins[0] <= 0;
        cyc(4);
        chk(irq_pending_r[2], 1'b1);
        serve <= 1;
        cyc(6);
        serve <= 0;
        cyc(2);
        chk(irq_pending_r[2], 1'b1);
        pin_forced_low[0] <= 1;
        cyc(4);
        chk(irq_pending_r[2], 1'b0);
        pin_forced_low[0] <= 0;
        pin_irq_en <= 16'h0408;
        wr(8'ha0, 8'h39);
        cyc(4);
        rd(8'hac, 32'h14);
        chk(irq_pending_r[4], 1'b1);
        pin_irq_en <= 16'h0;
        periph_req <= 11'h002;
        cyc(4);
        chk(wake_active_halt_r, 1'b1);
        chk(wake_halt_r, 1'b0);
        periph_req <= 11'h003;
        cyc(4);
        chk(top_addr_r, 16'hfffa);
        periph_req <= 11'h400;
        cyc(4);
        chk(top_addr_r, 16'hffe0);
        chk(wake_halt_r, 1'b0);
        stop_test;
    end
endmodule
